// File: verilog/usbe_pkg.sv
/*
 Shared constants for the endpoint state and counter logic and the host end:
 register offsets, field positions, status encodings, PIDs and handshake codes.
 Assumes a single 250 MHz clock domain on both ends of the link.
*/
`default_nettype none
package usbe_pkg;
	localparam int          CLK_PERIOD_NS = 4;
	// Host gives up waiting for an answer after this long
	localparam int          HOST_WAIT_NS  = 256;
	localparam logic [7:0]  HOST_WAIT_CYC = 8'(HOST_WAIT_NS / CLK_PERIOD_NS);

	localparam logic [7:0]  OFF_USBCTL  = 8'h22;
	localparam logic [7:0]  OFF_EP0     = 8'h25;
	localparam logic [7:0]  OFF_CNT0RX  = 8'h26;
	localparam logic [7:0]  OFF_CNT0TX  = 8'h27;
	localparam logic [7:0]  OFF_EP2RX   = 8'h2A;
	localparam logic [7:0]  OFF_CNT2RX  = 8'h2B;
	localparam logic [7:0]  OFF_DEVSTAT = 8'h35;
	localparam logic [7:0]  OFF_TXCTL [1:5] = '{8'h28, 8'h2C, 8'h2E, 8'h30, 8'h32};
	localparam logic [7:0]  OFF_TXCNT [1:5] = '{8'h29, 8'h2D, 8'h2F, 8'h31, 8'h33};

	// Endpoint control fields (transmit and receive endpoints)
	localparam int          F_DONE = 3;
	localparam int          F_TOG  = 2;
	// Control endpoint fields
	localparam int          F0_DONE  = 7;
	localparam int          F0_TTOG  = 6;
	localparam int          F0_TSTAT = 4;
	localparam int          F0_RTOG  = 2;
	localparam int          F0_RSTAT = 0;
	// Own status bits and force-reset bit
	localparam int          F_FORCE  = 0;
	localparam int          F_OVR    = 0;
	localparam int          F_RSTEV  = 1;

	localparam int          CNT_S_W = 4;
	localparam int          CNT_B_W = 7;
	localparam logic [7:0]  REG_RESET = 8'h00;

	localparam logic [1:0]  ST_DIS   = 2'h0;
	localparam logic [1:0]  ST_STALL = 2'h1;
	localparam logic [1:0]  ST_NAK   = 2'h2;
	localparam logic [1:0]  ST_VALID = 2'h3;

	localparam logic [1:0]  PID_OUT   = 2'h0;
	localparam logic [1:0]  PID_IN    = 2'h2;
	localparam logic [1:0]  PID_SETUP = 2'h3;

	localparam logic [1:0]  HS_ACK   = 2'h0;
	localparam logic [1:0]  HS_NAK   = 2'h1;
	localparam logic [1:0]  HS_STALL = 2'h2;
	localparam logic [1:0]  HS_NONE  = 2'h3;
endpackage
`default_nettype wire

// File: verilog/usbe_link_if.sv
/*
 Transaction-level link between the host end and the device endpoint logic.
 Both ends run on the same clock; every signal is driven from a flip-flop.
*/
`timescale 1ns/1ps
`default_nettype none
interface usbe_link_if;
	logic       tok_valid;
	logic [1:0] tok_pid;
	logic [2:0] tok_ep;
	logic       dat_valid;
	logic [7:0] dat_byte;
	logic       dat_end;
	logic       dat_pid;
	logic       dat_crc_ok;
	logic       ack;
	logic       bus_reset;
	logic       hs_valid;
	logic [1:0] hs_code;
	logic       in_valid;
	logic [6:0] in_len;
	logic       in_pid;

	modport dev (
		input  tok_valid, tok_pid, tok_ep, dat_valid, dat_byte, dat_end, dat_pid,
		input  dat_crc_ok, ack, bus_reset,
		output hs_valid, hs_code, in_valid, in_len, in_pid
	);
	modport host (
		output tok_valid, tok_pid, tok_ep, dat_valid, dat_byte, dat_end, dat_pid,
		output dat_crc_ok, ack, bus_reset,
		input  hs_valid, hs_code, in_valid, in_len, in_pid
	);
endinterface
`default_nettype wire

// File: verilog/usbe_dev.sv
/*
 Device end: endpoint handshake state, data toggles, done flags and byte
 counters, with a plain software register port. Assumes the host end keeps
 one transaction at a time and sends its data packet right after the token.
*/
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usbe_dev (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Link to host
	usbe_link_if.dev        link,
	// Software register port
	input  wire logic [7:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [7:0]      sw_rdata,
	// Accepted receive bytes
	output logic            rx_store_valid,
	output logic [7:0]      rx_store_byte
);
	import usbe_pkg::*;

	typedef enum logic [1:0] {S_IDLE = 2'b00, S_RX = 2'b01, S_TXW = 2'b10} usbe_st_e;

	usbe_st_e   st_q;
	logic [2:0] cur_ep_q;
	logic       cur_setup_q, cur_ovr_q;
	logic [1:0] mode_q;
	logic       e0_done_q, e0_ttog_q, e0_rtog_q;
	logic [1:0] e0_tstat_q, e0_rstat_q;
	logic [3:0] cnt0rx_q, cnt0tx_q;
	logic       r2_done_q, r2_tog_q;
	logic [1:0] r2_stat_q;
	logic [6:0] cnt2rx_q;
	logic       tx_done_q [1:5];
	logic       tx_tog_q  [1:5];
	logic [1:0] tx_stat_q [1:5];
	logic [6:0] tx_cnt_q  [1:5];
	logic       force_q, rst_prev_q, ovr_q, rstev_q;
	logic       hs_valid_q, in_valid_q, in_pid_q, rx_store_valid_q;
	logic [1:0] hs_code_q;
	logic [6:0] in_len_q;
	logic [7:0] rx_store_byte_q, rdata_q, rd_mux;

	logic       usb_rst, tok_go, is_in, is_setup, setup_go;
	logic [1:0] rx_sel, tx_sel, rx_mode;
	logic [6:0] tx_sel_cnt;
	logic       tx_sel_tog, rx_cnt_zero, cur_rtog, byte_take;
	logic       rx_end, rx_ack, rx_done, e0_stall, tx_ack;

	assign usb_rst  = link.bus_reset | force_q;
	assign tok_go   = link.tok_valid & ~usb_rst;
	assign is_in    = link.tok_pid == PID_IN;
	assign is_setup = (link.tok_pid == PID_SETUP) && (link.tok_ep == 3'h0);

	// Endpoint state selected by the incoming token
	always_comb begin
		rx_sel = ST_DIS;
		tx_sel = ST_DIS;
		tx_sel_cnt = 7'h00;
		tx_sel_tog = 1'b0;
		if (link.tok_ep == 3'h0) begin
			rx_sel = e0_rstat_q;
			tx_sel = e0_tstat_q;
			tx_sel_cnt = {3'h0, cnt0tx_q};
			tx_sel_tog = e0_ttog_q;
		end
		if (link.tok_ep == 3'h2) begin
			rx_sel = r2_stat_q;
		end
		for (int i = 1; i <= 5; i++) begin
			if (link.tok_ep == 3'(i)) begin
				tx_sel = tx_stat_q[i];
				tx_sel_cnt = tx_cnt_q[i];
				tx_sel_tog = tx_tog_q[i];
			end
		end
	end

	assign rx_mode  = is_setup ? ((rx_sel != ST_DIS) ? ST_VALID : ST_DIS) :
	                  (link.tok_pid == PID_OUT) ? rx_sel : ST_DIS;
	assign setup_go = tok_go & is_setup & (rx_sel != ST_DIS);

	assign rx_cnt_zero = (cur_ep_q == 3'h0) ? (cnt0rx_q == 4'h0) : (cnt2rx_q == 7'h00);
	assign cur_rtog    = (cur_ep_q == 3'h0) ? e0_rtog_q : r2_tog_q;
	assign byte_take = (st_q == S_RX) & link.dat_valid & (mode_q == ST_VALID) &
	                   ~rx_cnt_zero & ~usb_rst;
	assign rx_end  = (st_q == S_RX) & link.dat_end & ~usb_rst;
	assign rx_ack  = rx_end & (mode_q == ST_VALID) & link.dat_crc_ok & ~cur_ovr_q;
	assign rx_done = rx_ack & (link.dat_pid == cur_rtog);
	assign tx_ack  = (st_q == S_TXW) & link.ack & ~usb_rst;
	assign e0_stall = (tok_go & is_in & (link.tok_ep == 3'h0) & (tx_sel == ST_STALL)) |
	                  (rx_end & (mode_q == ST_STALL) & (cur_ep_q == 3'h0));

	// Transaction sequencing
	always_ff @(posedge clk) begin
		if (!rst_n || usb_rst) begin
			st_q <= S_IDLE;
			cur_ep_q <= 3'h0;
			cur_setup_q <= 1'b0;
			cur_ovr_q <= 1'b0;
			mode_q <= ST_DIS;
		end else if (tok_go) begin
			cur_ep_q <= link.tok_ep;
			cur_setup_q <= is_setup;
			cur_ovr_q <= 1'b0;
			mode_q <= rx_mode;
			if (is_in) begin
				st_q <= (tx_sel == ST_VALID) ? S_TXW : S_IDLE;
			end else begin
				st_q <= (rx_mode != ST_DIS) ? S_RX : S_IDLE;
			end
		end else begin
			case (st_q)
				S_RX: begin
					if (link.dat_valid && mode_q == ST_VALID && rx_cnt_zero) begin
						cur_ovr_q <= 1'b1;
					end
					if (link.dat_end) begin
						st_q <= S_IDLE;
					end
				end
				S_TXW: begin
					if (link.ack) begin
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// Handshake, IN data and store outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hs_valid_q <= 1'b0;
			hs_code_q <= HS_NONE;
			in_valid_q <= 1'b0;
			in_len_q <= 7'h00;
			in_pid_q <= 1'b0;
			rx_store_valid_q <= 1'b0;
			rx_store_byte_q <= 8'h00;
		end else begin
			hs_valid_q <= 1'b0;
			in_valid_q <= 1'b0;
			rx_store_valid_q <= byte_take;
			if (byte_take) begin
				rx_store_byte_q <= link.dat_byte;
			end
			if (tok_go && is_in && tx_sel == ST_VALID) begin
				in_valid_q <= 1'b1;
				in_len_q <= tx_sel_cnt;
				in_pid_q <= tx_sel_tog;
			end
			if (tok_go && is_in && (tx_sel == ST_STALL || tx_sel == ST_NAK)) begin
				hs_valid_q <= 1'b1;
				hs_code_q <= (tx_sel == ST_STALL) ? HS_STALL : HS_NAK;
			end
			if (rx_end && (rx_ack || mode_q == ST_STALL || mode_q == ST_NAK)) begin
				hs_valid_q <= 1'b1;
				hs_code_q <= rx_ack ? HS_ACK : (mode_q == ST_STALL) ? HS_STALL : HS_NAK;
			end
		end
	end

	// Control endpoint register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			e0_done_q <= 1'b0;
			e0_ttog_q <= 1'b0;
			e0_rtog_q <= 1'b0;
			e0_tstat_q <= ST_DIS;
			e0_rstat_q <= ST_DIS;
		end else begin
			if (sw_wr && sw_addr == OFF_EP0) begin
				e0_ttog_q <= sw_wdata[F0_TTOG];
				e0_tstat_q <= sw_wdata[F0_TSTAT +: 2];
				e0_rtog_q <= sw_wdata[F0_RTOG];
				e0_rstat_q <= sw_wdata[F0_RSTAT +: 2];
			end
			if (setup_go) begin
				e0_rtog_q <= 1'b0;
				e0_ttog_q <= 1'b1;
			end
			if (rx_ack && cur_ep_q == 3'h0 && (rx_done || cur_setup_q)) begin
				e0_rtog_q <= rx_done ? ~e0_rtog_q : e0_rtog_q;
				e0_rstat_q <= ST_NAK;
				e0_tstat_q <= ST_NAK;
			end
			if (tx_ack && cur_ep_q == 3'h0) begin
				e0_ttog_q <= ~e0_ttog_q;
				e0_tstat_q <= ST_NAK;
				e0_rstat_q <= ST_NAK;
			end
			if (e0_stall) begin
				e0_tstat_q <= ST_STALL;
				e0_rstat_q <= ST_STALL;
			end
			if (usb_rst) begin
				e0_ttog_q <= 1'b0;
				e0_tstat_q <= ST_DIS;
				e0_rtog_q <= 1'b0;
				e0_rstat_q <= ST_DIS;
			end
			// Set wins over a software clear in the same cycle
			e0_done_q <= (rx_ack && cur_ep_q == 3'h0 && (rx_done || cur_setup_q)) ||
			             (tx_ack && cur_ep_q == 3'h0) ||
			             (e0_done_q && !(sw_wr && sw_addr == OFF_EP0 && !sw_wdata[F0_DONE]));
		end
	end

	// Receive endpoint 2 register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r2_done_q <= 1'b0;
			r2_tog_q <= 1'b0;
			r2_stat_q <= ST_DIS;
		end else begin
			if (sw_wr && sw_addr == OFF_EP2RX) begin
				r2_tog_q <= sw_wdata[F_TOG];
				r2_stat_q <= sw_wdata[1:0];
			end
			if (rx_done && cur_ep_q == 3'h2) begin
				r2_tog_q <= ~r2_tog_q;
				r2_stat_q <= ST_NAK;
			end
			if (usb_rst) begin
				r2_tog_q <= 1'b0;
				r2_stat_q <= ST_DIS;
			end
			r2_done_q <= (rx_done && cur_ep_q == 3'h2) ||
			             (r2_done_q && !(sw_wr && sw_addr == OFF_EP2RX && !sw_wdata[F_DONE]));
		end
	end

	// Transmit endpoints 1 to 5
	for (genvar g = 1; g <= 5; g++) begin : g_tx
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				tx_done_q[g] <= 1'b0;
				tx_tog_q[g] <= 1'b0;
				tx_stat_q[g] <= ST_DIS;
				tx_cnt_q[g] <= 7'h00;
			end else begin
				if (sw_wr && sw_addr == OFF_TXCTL[g]) begin
					tx_tog_q[g] <= sw_wdata[F_TOG];
					tx_stat_q[g] <= sw_wdata[1:0];
				end
				if (sw_wr && sw_addr == OFF_TXCNT[g]) begin
					tx_cnt_q[g] <= (g == 2) ? sw_wdata[6:0] : {3'h0, sw_wdata[3:0]};
				end
				if (tx_ack && cur_ep_q == 3'(g)) begin
					tx_tog_q[g] <= ~tx_tog_q[g];
					tx_stat_q[g] <= ST_NAK;
				end
				if (usb_rst) begin
					tx_tog_q[g] <= 1'b0;
					tx_stat_q[g] <= ST_DIS;
				end
				tx_done_q[g] <= (tx_ack && cur_ep_q == 3'(g)) ||
				                (tx_done_q[g] && !(sw_wr && sw_addr == OFF_TXCTL[g] &&
				                                   !sw_wdata[F_DONE]));
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt0rx_q <= 4'h0;
			cnt0tx_q <= 4'h0;
			cnt2rx_q <= 7'h00;
		end else begin
			if (sw_wr && sw_addr == OFF_CNT0RX) begin
				cnt0rx_q <= sw_wdata[3:0];
			end else if (byte_take && cur_ep_q == 3'h0) begin
				cnt0rx_q <= cnt0rx_q - 4'h1;
			end
			if (sw_wr && sw_addr == OFF_CNT0TX) begin
				cnt0tx_q <= sw_wdata[3:0];
			end
			if (sw_wr && sw_addr == OFF_CNT2RX) begin
				cnt2rx_q <= sw_wdata[6:0];
			end else if (byte_take && cur_ep_q == 3'h2) begin
				cnt2rx_q <= cnt2rx_q - 7'h01;
			end
		end
	end

	// Force reset, overrun and reset-release status
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			force_q <= 1'b0;
			rst_prev_q <= 1'b0;
			ovr_q <= 1'b0;
			rstev_q <= 1'b0;
		end else begin
			if (sw_wr && sw_addr == OFF_USBCTL) begin
				force_q <= sw_wdata[F_FORCE];
			end
			rst_prev_q <= usb_rst;
			ovr_q <= (rx_end && mode_q == ST_VALID && cur_ovr_q) ||
			         (ovr_q && !(sw_wr && sw_addr == OFF_DEVSTAT && !sw_wdata[F_OVR]));
			rstev_q <= (rst_prev_q && !usb_rst) ||
			           (rstev_q && !(sw_wr && sw_addr == OFF_DEVSTAT && !sw_wdata[F_RSTEV]));
		end
	end

	// Read mux
	always_comb begin
		rd_mux = REG_RESET;
		case (sw_addr)
			OFF_USBCTL:  rd_mux = {7'h00, force_q};
			OFF_EP0:     rd_mux = {e0_done_q, e0_ttog_q, e0_tstat_q, 1'b0, e0_rtog_q, e0_rstat_q};
			OFF_CNT0RX:  rd_mux = {4'h0, cnt0rx_q};
			OFF_CNT0TX:  rd_mux = {4'h0, cnt0tx_q};
			OFF_EP2RX:   rd_mux = {4'h0, r2_done_q, r2_tog_q, r2_stat_q};
			OFF_CNT2RX:  rd_mux = {1'b0, cnt2rx_q};
			OFF_DEVSTAT: rd_mux = {6'h00, rstev_q, ovr_q};
			default:     rd_mux = REG_RESET;
		endcase
		for (int i = 1; i <= 5; i++) begin
			if (sw_addr == OFF_TXCTL[i]) begin
				rd_mux = {4'h0, tx_done_q[i], tx_tog_q[i], tx_stat_q[i]};
			end
			if (sw_addr == OFF_TXCNT[i]) begin
				rd_mux = {1'b0, tx_cnt_q[i]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= sw_rd ? rd_mux : 8'h00;
		end
	end

	assign sw_rdata       = rdata_q;
	assign rx_store_valid = rx_store_valid_q;
	assign rx_store_byte  = rx_store_byte_q;
	assign link.hs_valid  = hs_valid_q;
	assign link.hs_code   = hs_code_q;
	assign link.in_valid  = in_valid_q;
	assign link.in_len    = in_len_q;
	assign link.in_pid    = in_pid_q;
endmodule
`default_nettype wire

// File: verilog/usbe_host.sv
/*
 Host end: turns one user command into a token, an optional data packet and
 a wait for the device's answer, and ACKs IN data not marked bad. Assumes the
 device end sits on the same clock behind the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module usbe_host (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Link to device
	usbe_link_if.host       link,
	// Command
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_kind,
	input  wire logic [2:0] cmd_ep,
	input  wire logic [6:0] cmd_len,
	input  wire logic       cmd_pid,
	input  wire logic       cmd_crc_bad,
	input  wire logic       bus_reset_req,
	output logic            cmd_ready,
	// Result
	output logic            res_valid,
	output logic [1:0]      res_code,
	output logic            res_data,
	output logic [6:0]      res_len,
	output logic            res_pid
);
	import usbe_pkg::*;

	typedef enum logic [1:0] {H_IDLE = 2'b00, H_TOK = 2'b01, H_DATA = 2'b11, H_WAIT = 2'b10} usbe_hst_e;

	usbe_hst_e  h_q;
	logic       ready_q, tok_q, dv_q, de_q, dpid_q, crc_q, ack_q, brst_q;
	logic [1:0] kind_q, tpid_q, rcode_q;
	logic [2:0] tep_q;
	logic [6:0] len_q, cnt_q, rlen_q;
	logic [7:0] byte_q, wait_q;
	logic       pid_q, bad_q, rv_q, rdata_q, rpid_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			h_q <= H_IDLE;
			ready_q <= 1'b0;
			{tok_q, dv_q, de_q, ack_q, rv_q, dpid_q, crc_q, brst_q} <= 8'h00;
			{kind_q, tpid_q, rcode_q} <= 6'h00;
			tep_q <= 3'h0;
			{len_q, cnt_q, rlen_q} <= 21'h0;
			byte_q <= 8'h00;
			wait_q <= 8'h00;
			{pid_q, bad_q, rdata_q, rpid_q} <= 4'h0;
		end else begin
			tok_q <= 1'b0;
			dv_q <= 1'b0;
			de_q <= 1'b0;
			ack_q <= 1'b0;
			rv_q <= 1'b0;
			brst_q <= bus_reset_req;
			case (h_q)
				H_IDLE: begin
					ready_q <= 1'b1;
					if (cmd_valid && ready_q) begin
						ready_q <= 1'b0;
						tok_q <= 1'b1;
						tpid_q <= cmd_kind;
						tep_q <= cmd_ep;
						kind_q <= cmd_kind;
						len_q <= cmd_len;
						pid_q <= (cmd_kind == PID_SETUP) ? 1'b0 : cmd_pid;
						bad_q <= cmd_crc_bad;
						cnt_q <= 7'h00;
						wait_q <= 8'h00;
						h_q <= H_TOK;
					end
				end
				H_TOK: h_q <= (kind_q == PID_IN) ? H_WAIT : H_DATA;
				H_DATA: begin
					if (cnt_q != len_q) begin
						dv_q <= 1'b1;
						byte_q <= {1'b0, cnt_q};
						cnt_q <= cnt_q + 7'h01;
					end else begin
						de_q <= 1'b1;
						dpid_q <= pid_q;
						crc_q <= ~bad_q;
						h_q <= H_WAIT;
					end
				end
				H_WAIT: begin
					wait_q <= wait_q + 8'h01;
					if (link.hs_valid || link.in_valid || wait_q == HOST_WAIT_CYC) begin
						rv_q <= 1'b1;
						rcode_q <= link.hs_valid ? link.hs_code : HS_NONE;
						rdata_q <= link.in_valid;
						rlen_q <= link.in_len;
						rpid_q <= link.in_pid;
						// Corrupt IN data is left unacknowledged
						ack_q <= link.in_valid & ~bad_q;
						h_q <= H_IDLE;
					end
				end
				default: h_q <= H_IDLE;
			endcase
		end
	end

	assign cmd_ready       = ready_q;
	assign res_valid       = rv_q;
	assign res_code        = rcode_q;
	assign res_data        = rdata_q;
	assign res_len         = rlen_q;
	assign res_pid         = rpid_q;
	assign link.tok_valid  = tok_q;
	assign link.tok_pid    = tpid_q;
	assign link.tok_ep     = tep_q;
	assign link.dat_valid  = dv_q;
	assign link.dat_byte   = byte_q;
	assign link.dat_end    = de_q;
	assign link.dat_pid    = dpid_q;
	assign link.dat_crc_ok = crc_q;
	assign link.ack        = ack_q;
	assign link.bus_reset  = brst_q;
endmodule
`default_nettype wire

// File: verif/usbe_chk.sv
/*
 Assertions on the link between the host end and the device end.
 Assumes one clock and the bench's active-low synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module usbe_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Host to device
	input wire logic       tok_valid,
	input wire logic [1:0] tok_pid,
	input wire logic [2:0] tok_ep,
	input wire logic       dat_end,
	input wire logic       dat_crc_ok,
	input wire logic       bus_reset,
	// Device to host
	input wire logic       hs_valid,
	input wire logic [1:0] hs_code,
	input wire logic       in_valid,
	input wire logic [6:0] in_len
);
	import usbe_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic in_tok = tok_valid && tok_pid == PID_IN;
	logic      setup_q;

	// Remembers whether the last token was a setup
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			setup_q <= 1'h0;
		end else if (tok_valid) begin
			setup_q <= tok_pid == PID_SETUP;
		end
	end

	AST_IN_CAUSE: assert property (in_valid |-> $past(in_tok))
		else $error("IN data without an IN token");
	AST_HS_CAUSE: assert property (hs_valid |-> $past(dat_end) || $past(in_tok))
		else $error("Handshake without a packet or IN token");
	AST_ONE_ANSWER: assert property (!(hs_valid && in_valid))
		else $error("Data and handshake together");
	AST_ACK_GOOD: assert property (hs_valid && hs_code == HS_ACK |-> $past(dat_end && dat_crc_ok))
		else $error("ACK without a good data packet");
	AST_BAD_CRC: assert property (dat_end && !dat_crc_ok |=> !hs_valid)
		else $error("Handshake after a bad packet");
	AST_RESET_QUIET: assert property (bus_reset [*2] |-> !in_valid && !hs_valid)
		else $error("Answer during bus reset");
	AST_LEN_4BIT: assert property (in_valid && $past(tok_ep) != 3'h2 |-> in_len <= 7'h0F)
		else $error("IN length beyond a four-bit count");
	AST_SETUP_ACK: assert property (hs_valid && setup_q |-> hs_code == HS_ACK)
		else $error("Setup answered other than ACK");

	cover property (in_valid);
	cover property (hs_valid && hs_code == HS_STALL);
	cover property (hs_valid && hs_code == HS_NAK);
	cover property (hs_valid && setup_q);
endmodule
`default_nettype wire

// File: verif/usb_endpoint_state_and_counters_test.sv
/*
 Self-checking bench: host end and device end joined by the link interface,
 with the link checker beside it. Assumes the register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_state_and_counters_test;
	import usbe_pkg::*;
	localparam logic [1:0] TXHS [4] = '{HS_NONE, HS_STALL, HS_NAK, HS_NONE};
	localparam logic [7:0] RSV [6] = '{OFF_EP0, OFF_CNT0RX, OFF_CNT0TX, OFF_EP2RX,
		OFF_CNT2RX, OFF_DEVSTAT};
	logic            clk = 1'h0;
	logic            rst_n = 1'h0;
	logic            sw_wr = 1'h0;
	logic            sw_rd = 1'h0;
	logic [7:0]      sw_addr = 8'h00;
	logic [7:0]      sw_wdata = 8'h00;
	logic            cmd_valid = 1'h0;
	logic [1:0]      cmd_kind = 2'h0;
	logic [2:0]      cmd_ep = 3'h0;
	logic [6:0]      cmd_len = 7'h00;
	logic            cmd_pid = 1'h0;
	logic            cmd_crc_bad = 1'h0;
	logic            bus_reset_req = 1'h0;
	wire logic [7:0] sw_rdata, rx_store_byte;
	wire logic [6:0] res_len;
	wire logic [1:0] res_code;
	wire logic       rx_store_valid, cmd_ready, res_valid, res_data, res_pid;
	logic [7:0]      r_code, r_dat, r_len, r_pid, last_b;
	int              n_errors = 0;
	int              num_checks = 0;
	int              cyc = 0;
	int              n_st = 0;

	usbe_link_if lk ();
	usbe_dev i_usbe_dev (.clk, .rst_n, .link(lk), .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
		.sw_rdata, .rx_store_valid, .rx_store_byte);
	usbe_host i_usbe_host (.clk, .rst_n, .link(lk), .cmd_valid, .cmd_kind, .cmd_ep,
		.cmd_len, .cmd_pid, .cmd_crc_bad, .bus_reset_req, .cmd_ready, .res_valid,
		.res_code, .res_data, .res_len, .res_pid);
	usbe_chk i_usbe_chk (.clk, .rst_n, .tok_valid(lk.tok_valid), .tok_pid(lk.tok_pid),
		.tok_ep(lk.tok_ep), .dat_end(lk.dat_end), .dat_crc_ok(lk.dat_crc_ok),
		.bus_reset(lk.bus_reset), .hs_valid(lk.hs_valid), .hs_code(lk.hs_code),
		.in_valid(lk.in_valid), .in_len(lk.in_len));

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	// Counts stored bytes; the ceiling cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (rx_store_valid === 1'h1) begin
			n_st++;
			last_b = rx_store_byte;
		end
		if (cyc == 5000) begin
			n_errors++;
			complete_run;
		end
	end

	task automatic complete_run;
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// A trailing idle cycle keeps two writes from touching the strobe in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'h1;
		@(posedge clk);
		sw_wr <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sw_addr <= a;
		sw_rd <= 1'h1;
		@(posedge clk);
		sw_rd <= 1'h0;
		@(posedge clk);
		chk(sw_rdata, e);
	endtask

	task automatic xfer(input logic [1:0] k, input logic [2:0] e, input logic [6:0] l,
		input logic p, input logic b);
		int n;
		cmd_kind <= k;
		cmd_ep <= e;
		cmd_len <= l;
		cmd_pid <= p;
		cmd_crc_bad <= b;
		cmd_valid <= 1'h1;
		n = 0;
		do @(posedge clk); while (cmd_ready !== 1'h1 && n++ < 200);
		cmd_valid <= 1'h0;
		if (n > 200) begin
			n_errors++;
			complete_run;
		end
		n = 0;
		do @(posedge clk); while (res_valid !== 1'h1 && n++ < 200);
		if (n > 200) begin
			n_errors++;
			complete_run;
		end
		r_code = 8'(res_code);
		r_dat = 8'(res_data);
		r_len = 8'(res_len);
		r_pid = 8'(res_pid);
	endtask

	task automatic hs(input logic [1:0] c, input logic d);
		chk(r_code, 8'(c));
		chk(r_dat, 8'(d));
	endtask

	task automatic t_regs;
		for (int i = 1; i <= 5; i++) begin
			rd(OFF_TXCTL[i], REG_RESET);
			rd(OFF_TXCNT[i], REG_RESET);
		end
		foreach (RSV[i]) rd(RSV[i], REG_RESET);
		wr(OFF_TXCTL[1], 8'hFF);
		rd(OFF_TXCTL[1], 8'h07);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		wr(OFF_CNT2RX, 8'hFF);
		rd(OFF_CNT2RX, 8'h7F);
	endtask

	task automatic t_tx;
		for (int e = 1; e <= 4; e++) begin
			wr(OFF_TXCNT[e], 8'h0F);
			wr(OFF_TXCTL[e], 8'(e - 1));
			xfer(PID_IN, 3'(e), 7'h00, 1'h0, 1'h0);
			hs(TXHS[e - 1], 1'(e == 4));
			rd(OFF_TXCTL[e], (e == 4) ? 8'h0E : 8'(e - 1));
		end
		chk(r_len, 8'h0F);
		chk(r_pid, 8'h00);
		wr(OFF_TXCTL[4], 8'h07);
		xfer(PID_IN, 3'h4, 7'h00, 1'h0, 1'h1);
		chk(r_pid, 8'h01);
		rd(OFF_TXCTL[4], 8'h07);
	endtask

	task automatic t_ep0;
		int n0;
		wr(OFF_CNT0RX, 8'h08);
		wr(OFF_EP0, 8'h37);
		n0 = n_st;
		xfer(PID_SETUP, 3'h0, 7'h03, 1'h0, 1'h0);
		hs(HS_ACK, 1'h0);
		rd(OFF_EP0, 8'hE6);
		rd(OFF_CNT0RX, 8'h05);
		chk(8'(n_st - n0), 8'h03);
		chk(last_b, 8'h02);
		wr(OFF_CNT0TX, 8'h05);
		wr(OFF_EP0, 8'h73);
		xfer(PID_IN, 3'h0, 7'h00, 1'h0, 1'h0);
		hs(HS_NONE, 1'h1);
		chk(r_len, 8'h05);
		chk(r_pid, 8'h01);
		rd(OFF_EP0, 8'hA2);
		wr(OFF_EP0, 8'h31);
		xfer(PID_OUT, 3'h0, 7'h01, 1'h1, 1'h0);
		hs(HS_STALL, 1'h0);
		rd(OFF_EP0, 8'h11);
	endtask

	task automatic t_rx;
		int n0;
		for (int s = 0; s < 3; s++) begin
			wr(OFF_EP2RX, 8'(s));
			xfer(PID_OUT, 3'h2, 7'h01, 1'h0, 1'h0);
			hs(TXHS[s], 1'h0);
		end
		wr(OFF_CNT2RX, 8'h03);
		wr(OFF_EP2RX, 8'h03);
		xfer(PID_OUT, 3'h2, 7'h02, 1'h0, 1'h0);
		hs(HS_ACK, 1'h0);
		rd(OFF_EP2RX, 8'h0E);
		rd(OFF_CNT2RX, 8'h01);
		wr(OFF_EP2RX, 8'h07);
		xfer(PID_OUT, 3'h2, 7'h01, 1'h0, 1'h0);
		hs(HS_ACK, 1'h0);
		xfer(PID_OUT, 3'h2, 7'h00, 1'h1, 1'h1);
		hs(HS_NONE, 1'h0);
		rd(OFF_EP2RX, 8'h07);
		rd(OFF_DEVSTAT, 8'h00);
		wr(OFF_CNT2RX, 8'h01);
		n0 = n_st;
		xfer(PID_OUT, 3'h2, 7'h03, 1'h1, 1'h0);
		hs(HS_NONE, 1'h0);
		chk(8'(n_st - n0), 8'h01);
		rd(OFF_CNT2RX, 8'h00);
		rd(OFF_DEVSTAT, 8'h01);
	endtask

	task automatic t_rst;
		bus_reset_req <= 1'h1;
		repeat (4) @(posedge clk);
		bus_reset_req <= 1'h0;
		repeat (4) @(posedge clk);
		rd(OFF_EP2RX, 8'h00);
		rd(OFF_TXCTL[4], 8'h00);
		rd(OFF_EP0, 8'h00);
		rd(OFF_TXCNT[1], 8'h0F);
		wr(OFF_USBCTL, 8'h01);
		wr(OFF_TXCTL[3], 8'h03);
		rd(OFF_TXCTL[3], 8'h00);
		wr(OFF_USBCTL, 8'h00);
		rd(OFF_DEVSTAT, 8'h03);
		wr(OFF_TXCTL[4], 8'h03);
		xfer(PID_IN, 3'h4, 7'h00, 1'h0, 1'h0);
		hs(HS_NONE, 1'h1);
		chk(r_pid, 8'h00);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_regs;
		t_tx;
		t_ep0;
		t_rx;
		t_rst;
		complete_run;
	end
endmodule
`default_nettype wire
